// >>> common/ccd_pkg.sv
// Package: register map, field layouts and timing for the clock divide/delay block
package ccd_pkg;

  localparam logic [7:0]  CTRL_OFS     = 8'h00;
  localparam logic [7:0]  STAT_OFS     = 8'h04;
  localparam logic [7:0]  OUT_BASE_OFS = 8'h10;

  localparam int          NUM_REF      = 3;
  localparam int          NUM_OUT      = 6;
  localparam int          OSC_OUT_A    = 3;
  localparam int          OSC_OUT_B    = 4;

  localparam logic [1:0]  REF_MANUAL   = 2'h0;
  localparam logic [1:0]  REF_PIN      = 2'h1;
  localparam logic [1:0]  REF_AUTO     = 2'h2;
  localparam logic [1:0]  B_AS_REF     = 2'h0;
  localparam logic [1:0]  B_AS_FB      = 2'h1;
  localparam logic [1:0]  B_AS_EXTVCO  = 2'h2;
  localparam logic [2:0]  FB_EXTERNAL  = 3'h6;

  localparam logic [10:0] DIV_MIN      = 11'h001;
  localparam logic [10:0] DIV_MAX      = 11'h415;
  localparam logic [10:0] DIV_EXT      = 11'h01a;
  localparam logic [9:0]  DLY_NRM_MIN  = 10'h005;
  localparam logic [9:0]  DLY_NRM_MAX  = 10'h00c;
  localparam logic [9:0]  DLY_EXT_MIN  = 10'h00d;
  localparam logic [9:0]  DLY_EXT_MAX  = 10'h20a;
  localparam logic [2:0]  VDIV_MIN     = 3'h2;
  localparam logic [4:0]  FINE_MAX     = 5'h13;
  localparam logic [9:0]  FINE_STEP_PS = 10'h019;
  localparam logic [9:0]  FINE_OFS_PS  = 10'h1f4;

  localparam int          CLK_PERIOD_PS = 5000;
  localparam int          LOS_TIME_NS   = 1000;
  localparam int          LOS_CYC       = (LOS_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int          LOS_W         = $clog2(LOS_CYC + 1);
  localparam int          CNT_W         = 14;

  typedef struct packed {
    logic [5:0] rsv;
    logic       osc_out_bypass;
    logic       xtal_mode;
    logic       sync_sw;
    logic       zero_delay_en;
    logic [2:0] fb_sel;
    logic [2:0] vco_div;
    logic       vco_div_en;
    logic [2:0] osc_div_m1;
    logic [1:0] prediv_c;
    logic [1:0] prediv_b;
    logic [1:0] prediv_a;
    logic [1:0] b_use;
    logic [1:0] ref_manual;
    logic [1:0] ref_mode;
  } ccd_ctrl_s;

  typedef struct packed {
    logic        rsv;
    logic        fine_en;
    logic [4:0]  fine_code;
    logic        osc_bypass;
    logic        osc_src;
    logic        sync_exempt_bit;
    logic        delay_half_step_bit;
    logic [9:0]  coarse_dly;
    logic [10:0] div;
  } ccd_out_cfg_s;

  localparam logic [31:0] CTRL_RST = 32'h0002_0002;
  localparam logic [31:0] OUT_RST  = 32'h0000_2801;

endpackage

// >>> src/ccd_clock_divide_delay.sv
// Reference selection, oscillator/VCO dividers, output dividers, delay and sync
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
module ccd_clock_divide_delay #(
  parameter int NUM_OUT = ccd_pkg::NUM_OUT
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                ref_input_a,
  input  wire logic                ref_input_b,
  input  wire logic                ref_input_c,
  input  wire logic [2:0]          ref_status_pin_i,
  output logic      [2:0]          ref_status_pin_o,
  output logic      [2:0]          ref_status_pin_oe,
  input  wire logic                oscillator_input,
  input  wire logic                sync_in,
  output logic                     ref_to_pll,
  output logic                     path_clk,
  output logic                     oscillator_buffered_output,
  output logic      [NUM_OUT-1:0]  clk_out,
  output logic                     feedback_clk,
  output logic                     xtal_enable,
  output logic [NUM_OUT-1:0][9:0]  fine_delay_ps
);

  // Pin vector: [2:0] refs, [5:3] status pins, 6 osc, 7 sync
  localparam int PW = 8;
  localparam int OSC = 6;
  localparam int SYN = 7;

  ccd_pkg::ccd_ctrl_s                     ctrl_ff, nxt_ctrl;
  ccd_pkg::ccd_out_cfg_s [NUM_OUT-1:0]    cfg_ff, nxt_cfg;
  logic [31:0]                            prdata_ff, nxt_prdata;
  logic                                   pready_ff, nxt_pready;
  logic                                   pslverr_ff, nxt_pslverr;

  logic [PW-1:0]                          s1_ff, s2_ff, s3_ff, filt_ff, prev_ff;
  logic [PW-1:0]                          nxt_filt;
  logic [2:0][2:0]                        rcnt_ff, nxt_rcnt;
  logic [2:0][ccd_pkg::LOS_W-1:0]         los_cnt_ff, nxt_los_cnt;
  logic [2:0]                             los;
  logic [1:0]                             sel_ff, nxt_sel;
  logic [2:0]                             ocnt_ff, nxt_ocnt;
  logic                                   odiv_ff, nxt_odiv;
  logic [2:0]                             pcnt_ff, nxt_pcnt;
  logic                                   pclk_lvl_ff, nxt_pclk_lvl;
  logic [NUM_OUT-1:0][ccd_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [NUM_OUT-1:0]                     wait_ff, nxt_wait;
  logic [NUM_OUT-1:0]                     lvl_ff, nxt_lvl;
  logic [NUM_OUT-1:0]                     out_ff, nxt_out;
  logic                                   ref_ff, nxt_ref;
  logic                                   obuf_ff, nxt_obuf;
  logic                                   fb_ff, nxt_fb;
  logic [2:0]                             st_o_ff, nxt_st_o;
  logic [2:0]                             st_oe_ff, nxt_st_oe;
  logic [NUM_OUT-1:0][9:0]                fine_ff, nxt_fine;

  logic                                   sync_act;
  logic [2:0]                             path_div;
  logic [2:0]                             ref_lvl;
  logic [2:0]                             ref_ok;
  logic [NUM_OUT-1:0]                     ext_mode;

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (st[b])
      begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Pre-divided level: ratio 2^k taken from a rising-edge counter
  function automatic logic prediv(input logic lvl, input logic [2:0] cnt, input logic [1:0] k);
    logic r;
    r = lvl;
    if (k != 2'h0)
    begin
      r = cnt[k - 2'h1];
    end
    return r;
  endfunction

  function automatic logic [10:0] div_clamp(input logic [10:0] d);
    logic [10:0] r;
    r = d;
    if (d < ccd_pkg::DIV_MIN)
    begin
      r = ccd_pkg::DIV_MIN;
    end
    else if (d > ccd_pkg::DIV_MAX)
    begin
      r = ccd_pkg::DIV_MAX;
    end
    return r;
  endfunction

  // Coarse delay in half path periods, clamped to the mode's range
  function automatic logic [10:0] dly_half(input ccd_pkg::ccd_out_cfg_s c);
    logic [9:0]  d;
    logic        ext;
    logic [10:0] r;
    ext = div_clamp(c.div) >= ccd_pkg::DIV_EXT;
    d = c.coarse_dly;
    if (ext)
    begin
      if (d < ccd_pkg::DLY_EXT_MIN) d = ccd_pkg::DLY_EXT_MIN;
      if (d > ccd_pkg::DLY_EXT_MAX) d = ccd_pkg::DLY_EXT_MAX;
    end
    else
    begin
      if (d < ccd_pkg::DLY_NRM_MIN) d = ccd_pkg::DLY_NRM_MIN;
      if (d > ccd_pkg::DLY_NRM_MAX) d = ccd_pkg::DLY_NRM_MAX;
    end
    r = {d, 1'b0};
    if (c.delay_half_step_bit && div_clamp(c.div) > ccd_pkg::DIV_MIN)
    begin
      r = r - 11'h001;
    end
    return r;
  endfunction

  assign prdata                     = prdata_ff;
  assign pready                     = pready_ff;
  assign pslverr                    = pslverr_ff;
  assign ref_to_pll                 = ref_ff;
  assign path_clk                   = pclk_lvl_ff;
  assign oscillator_buffered_output = obuf_ff;
  assign clk_out                    = out_ff;
  assign feedback_clk               = fb_ff;
  assign xtal_enable                = ctrl_ff.xtal_mode;
  assign ref_status_pin_o           = st_o_ff;
  assign ref_status_pin_oe          = st_oe_ff;
  assign fine_delay_ps              = fine_ff;

  assign sync_act = filt_ff[SYN] | ctrl_ff.sync_sw;
  assign path_div = !ctrl_ff.vco_div_en ? 3'h1 :
                    (ctrl_ff.vco_div < ccd_pkg::VDIV_MIN) ? ccd_pkg::VDIV_MIN :
                    ctrl_ff.vco_div;

  // APB slave: answer in the access cycle, write at the access edge
  always_comb
  begin
    nxt_ctrl    = ctrl_ff;
    nxt_cfg     = cfg_ff;
    nxt_prdata  = prdata_ff;
    nxt_pready  = 1'b0;
    nxt_pslverr = 1'b0;
    if (psel && !penable)
    begin
      nxt_pready  = 1'b1;
      nxt_prdata  = 32'h0000_0000;
      if (paddr == ccd_pkg::CTRL_OFS)
      begin
        nxt_prdata = ctrl_ff;
      end
      else if (paddr == ccd_pkg::STAT_OFS)
      begin
        nxt_prdata = {20'h00000, sync_act, ext_mode, los, sel_ff};
      end
      else if (paddr >= ccd_pkg::OUT_BASE_OFS && paddr[1:0] == 2'h0 &&
               paddr < ccd_pkg::OUT_BASE_OFS + 8'(4 * NUM_OUT))
      begin
        nxt_prdata = cfg_ff[paddr[7:2] - ccd_pkg::OUT_BASE_OFS[7:2]];
      end
      else
      begin
        nxt_pslverr = 1'b1;
      end
    end
    if (psel && penable && pready_ff)
    begin
      nxt_pready  = 1'b0;
      if (pwrite && !pslverr_ff)
      begin
        if (paddr == ccd_pkg::CTRL_OFS)
        begin
          nxt_ctrl = strb_merge(ctrl_ff, pwdata, pstrb);
        end
        else if (paddr != ccd_pkg::STAT_OFS)
        begin
          nxt_cfg[paddr[7:2] - ccd_pkg::OUT_BASE_OFS[7:2]] =
            strb_merge(cfg_ff[paddr[7:2] - ccd_pkg::OUT_BASE_OFS[7:2]], pwdata, pstrb);
        end
      end
    end
    if (!psel)
    begin
      nxt_pslverr = 1'b0;
    end
  end

  // Pin filter: a change counts once the second and third stages agree
  always_comb
  begin
    nxt_filt = (s2_ff & s3_ff) | (filt_ff & (s2_ff | s3_ff));
  end

  // Reference pre-dividers, loss detection and selection
  always_comb
  begin
    logic [1:0] pk;
    logic [1:0] cand;
    pk          = 2'h0;
    cand        = 2'h0;
    nxt_rcnt    = rcnt_ff;
    nxt_los_cnt = los_cnt_ff;
    nxt_sel     = sel_ff;
    for (int r = 0; r < 3; r++)
    begin
      if (filt_ff[r] && !prev_ff[r])
      begin
        nxt_rcnt[r] = rcnt_ff[r] + 3'h1;
      end
      if (filt_ff[r] != prev_ff[r])
      begin
        nxt_los_cnt[r] = '0;
      end
      else if (los_cnt_ff[r] != ccd_pkg::LOS_W'(ccd_pkg::LOS_CYC))
      begin
        nxt_los_cnt[r] = los_cnt_ff[r] + 1'b1;
      end
      los[r]    = los_cnt_ff[r] == ccd_pkg::LOS_W'(ccd_pkg::LOS_CYC);
      pk        = (r == 0) ? ctrl_ff.prediv_a : (r == 1) ? ctrl_ff.prediv_b : ctrl_ff.prediv_c;
      ref_lvl[r] = prediv(filt_ff[r], rcnt_ff[r], pk);
    end
    ref_ok = ~los & {1'b1, ctrl_ff.b_use == ccd_pkg::B_AS_REF, 1'b1};
    case (ctrl_ff.ref_mode)
      ccd_pkg::REF_MANUAL:
      begin
        if (ctrl_ff.ref_manual != 2'h3 &&
            !(ctrl_ff.ref_manual == 2'h1 && ctrl_ff.b_use != ccd_pkg::B_AS_REF))
        begin
          nxt_sel = ctrl_ff.ref_manual;
        end
      end
      ccd_pkg::REF_PIN:
      begin
        if (filt_ff[3])
        begin
          nxt_sel = 2'h0;
        end
        else if (filt_ff[4] && ctrl_ff.b_use == ccd_pkg::B_AS_REF)
        begin
          nxt_sel = 2'h1;
        end
        else if (filt_ff[5])
        begin
          nxt_sel = 2'h2;
        end
      end
      default:
      begin
        if (!ref_ok[sel_ff])
        begin
          cand = (sel_ff == 2'h2) ? 2'h0 : sel_ff + 2'h1;
          if (!ref_ok[cand])
          begin
            cand = (cand == 2'h2) ? 2'h0 : cand + 2'h1;
          end
          if (ref_ok[cand])
          begin
            nxt_sel = cand;
          end
        end
      end
    endcase
    nxt_ref   = (sel_ff == 2'h3) ? 1'b0 : ref_lvl[sel_ff];
    nxt_st_oe = (ctrl_ff.ref_mode == ccd_pkg::REF_PIN) ? 3'h0 : 3'h7;
    nxt_st_o  = los;
  end

  // Oscillator divider counts half periods so odd ratios keep 50 percent duty
  always_comb
  begin
    nxt_ocnt = ocnt_ff;
    nxt_odiv = odiv_ff;
    if (filt_ff[OSC] != prev_ff[OSC])
    begin
      if (ocnt_ff >= ctrl_ff.osc_div_m1)
      begin
        nxt_ocnt = 3'h0;
        nxt_odiv = ~odiv_ff;
      end
      else
      begin
        nxt_ocnt = ocnt_ff + 3'h1;
      end
    end
    nxt_obuf = !sync_act &&
               (ctrl_ff.osc_out_bypass ? filt_ff[OSC] : odiv_ff);
  end

  // Distribution path clock; one pclk stands for half a VCO period
  always_comb
  begin
    nxt_pcnt     = pcnt_ff + 3'h1;
    nxt_pclk_lvl = pclk_lvl_ff;
    if (pcnt_ff >= path_div - 3'h1)
    begin
      nxt_pcnt     = 3'h0;
      nxt_pclk_lvl = ~pclk_lvl_ff;
    end
  end

  // Output dividers with coarse delay
  always_comb
  begin
    logic [ccd_pkg::CNT_W-1:0] half;
    logic [ccd_pkg::CNT_W-1:0] wt;
    logic                      held;
    half     = '0;
    wt       = '0;
    held     = 1'b0;
    nxt_cnt  = cnt_ff;
    nxt_wait = wait_ff;
    nxt_lvl  = lvl_ff;
    for (int i = 0; i < NUM_OUT; i++)
    begin
      ext_mode[i] = div_clamp(cfg_ff[i].div) >= ccd_pkg::DIV_EXT;
      half = ccd_pkg::CNT_W'(div_clamp(cfg_ff[i].div)) * ccd_pkg::CNT_W'(path_div);
      wt   = ccd_pkg::CNT_W'(dly_half(cfg_ff[i])) * ccd_pkg::CNT_W'(path_div);
      held = sync_act && !cfg_ff[i].sync_exempt_bit;
      if (held)
      begin
        // Delay is only loaded here, so a new value waits for a sync
        nxt_lvl[i]  = 1'b0;
        nxt_wait[i] = 1'b1;
        nxt_cnt[i]  = wt - 1'b1;
      end
      else if (cnt_ff[i] != '0)
      begin
        nxt_cnt[i] = cnt_ff[i] - 1'b1;
      end
      else
      begin
        nxt_wait[i] = 1'b0;
        nxt_lvl[i]  = wait_ff[i] ? 1'b1 : ~lvl_ff[i];
        nxt_cnt[i]  = half - 1'b1;
      end
      nxt_out[i] = nxt_lvl[i];
      if ((i == ccd_pkg::OSC_OUT_A || i == ccd_pkg::OSC_OUT_B) && cfg_ff[i].osc_src)
      begin
        nxt_out[i] = !held &&
                     (cfg_ff[i].osc_bypass ? filt_ff[OSC] : odiv_ff);
      end
      nxt_fine[i] = 10'h000;
      if (cfg_ff[i].fine_en)
      begin
        nxt_fine[i] = ccd_pkg::FINE_OFS_PS + fine_ps(cfg_ff[i].fine_code);
      end
    end
  end

  function automatic logic [9:0] fine_ps(input logic [4:0] code);
    logic [4:0] c;
    c = (code > ccd_pkg::FINE_MAX) ? ccd_pkg::FINE_MAX : code;
    return 10'(c * ccd_pkg::FINE_STEP_PS);
  endfunction

  // Zero-delay feedback mux
  always_comb
  begin
    nxt_fb = 1'b0;
    if (ctrl_ff.zero_delay_en)
    begin
      if (ctrl_ff.fb_sel >= ccd_pkg::FB_EXTERNAL)
      begin
        nxt_fb = (ctrl_ff.b_use == ccd_pkg::B_AS_FB) && filt_ff[1];
      end
      else if (32'(ctrl_ff.fb_sel) < NUM_OUT)
      begin
        nxt_fb = out_ff[ctrl_ff.fb_sel];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff     <= ccd_pkg::CTRL_RST;
      cfg_ff      <= {NUM_OUT{ccd_pkg::OUT_RST}};
      prdata_ff   <= 32'h0000_0000;
      pready_ff   <= 1'b0;
      pslverr_ff  <= 1'b0;
      s1_ff       <= '0;
      s2_ff       <= '0;
      s3_ff       <= '0;
      filt_ff     <= '0;
      prev_ff     <= '0;
      rcnt_ff     <= '0;
      los_cnt_ff  <= '0;
      sel_ff      <= 2'h0;
      ocnt_ff     <= 3'h0;
      odiv_ff     <= 1'b0;
      pcnt_ff     <= 3'h0;
      pclk_lvl_ff <= 1'b0;
      cnt_ff      <= '0;
      wait_ff     <= '0;
      lvl_ff      <= '0;
      out_ff      <= '0;
      ref_ff      <= 1'b0;
      obuf_ff     <= 1'b0;
      fb_ff       <= 1'b0;
      st_o_ff     <= 3'h0;
      st_oe_ff    <= 3'h0;
      fine_ff     <= '0;
    end
    else
    begin
      ctrl_ff     <= nxt_ctrl;
      cfg_ff      <= nxt_cfg;
      prdata_ff   <= nxt_prdata;
      pready_ff   <= nxt_pready;
      pslverr_ff  <= nxt_pslverr;
      s1_ff       <= {sync_in, oscillator_input, ref_status_pin_i,
                      ref_input_c, ref_input_b, ref_input_a};
      s2_ff       <= s1_ff;
      s3_ff       <= s2_ff;
      filt_ff     <= nxt_filt;
      prev_ff     <= filt_ff;
      rcnt_ff     <= nxt_rcnt;
      los_cnt_ff  <= nxt_los_cnt;
      sel_ff      <= nxt_sel;
      ocnt_ff     <= nxt_ocnt;
      odiv_ff     <= nxt_odiv;
      pcnt_ff     <= nxt_pcnt;
      pclk_lvl_ff <= nxt_pclk_lvl;
      cnt_ff      <= nxt_cnt;
      wait_ff     <= nxt_wait;
      lvl_ff      <= nxt_lvl;
      out_ff      <= nxt_out;
      ref_ff      <= nxt_ref;
      obuf_ff     <= nxt_obuf;
      fb_ff       <= nxt_fb;
      st_o_ff     <= nxt_st_o;
      st_oe_ff    <= nxt_st_oe;
      fine_ff     <= nxt_fine;
    end
  end

endmodule

// >>> test/ccd_chk_assertions.sv
// Port-level checker for the clock divide/delay block and its bind
`timescale 1ns/10ps
module ccd_chk #(
  parameter int NUM_OUT = ccd_pkg::NUM_OUT
) (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic [2:0]              ref_status_pin_oe,
  input wire logic                    sync_in,
  input wire logic                    oscillator_buffered_output,
  input wire logic                    xtal_enable,
  input wire logic [NUM_OUT-1:0][9:0] fine_delay_ps
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property fine_ok(logic [9:0] v);
    v == 10'h000 || (v >= 10'h1f4 && v <= 10'h3cf && (v - 10'h1f4) % 25 == 0);
  endproperty

  AST_APB_READY: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_APB_PULSE: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  AST_APB_CAUSE: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  AST_APB_ERR: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");
  AST_PIN_DIR: assert property (ref_status_pin_oe == 3'h0 || ref_status_pin_oe == 3'h7)
    else $error("status pins half driven");
  AST_OSC_LOW: assert property (sync_in [*8] |-> !oscillator_buffered_output)
    else $error("oscillator output runs during sync");
  AST_FINE_FIRST: assert property (fine_ok(fine_delay_ps[0]))
    else $error("fine delay off grid");
  AST_FINE_LAST: assert property (fine_ok(fine_delay_ps[NUM_OUT-1]))
    else $error("fine delay off grid");
  AST_XTAL_WR: assert property ($changed(xtal_enable) |-> $past(pwrite) && $past(pready))
    else $error("crystal mode changed without write");

  cover property (pslverr);
  cover property (sync_in [*8]);
  cover property (ref_status_pin_oe == 3'h0);
endmodule

bind ccd_clock_divide_delay ccd_chk #(.NUM_OUT(NUM_OUT)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_status_pin_oe(ref_status_pin_oe),
  .sync_in(sync_in), .oscillator_buffered_output(oscillator_buffered_output),
  .xtal_enable(xtal_enable), .fine_delay_ps(fine_delay_ps)
);

// >>> test/ccd_ref_model.sv
// Free-running reference and oscillator sources at the block's input pins
`timescale 1ns/10ps
module ccd_ref_model (
  output logic ref_input_a,
  output logic ref_input_b,
  output logic ref_input_c,
  output logic oscillator_input
);
  initial
  begin
    {ref_input_a, ref_input_b, ref_input_c, oscillator_input} = 4'h0;
  end
  // Unrelated rates per input, as the pre-dividers expect
  // Each level lasts over two clock periods so the pin filter sees every edge
  always #17 ref_input_a = ~ref_input_a;
  always #23 ref_input_b = ~ref_input_b;
  always #29 ref_input_c = ~ref_input_c;
  always #13 oscillator_input = ~oscillator_input;
endmodule

// >>> test/test_clock_divide_delay_distribution.sv
// Self-checking bench for the clock divide/delay block
`timescale 1ns/10ps
module test_clock_divide_delay_distribution;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic            pclk = 1'b0;
  logic            presetn = 1'b0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [7:0]      paddr = 8'h00;
  logic [31:0]     pwdata = 32'h0;
  logic [3:0]      pstrb = 4'hf;
  logic [2:0]      pin_drv = 3'h0;
  logic            sync_in = 1'b0;
  logic [31:0]     prdata;
  logic            pready, pslverr, ra, rb, rc, osc, obuf, xtal;
  logic            ref_o, path, fbk;
  logic [2:0]      st_o, st_oe, st_i;
  logic [5:0]      clk_out;
  logic [5:0][9:0] fine;
  logic [31:0]     exp_q[$];
  logic [31:0]     msk_q[$];
  logic            err_q[$];
  int              n_mismatch = 0;
  int              cmp_count = 0;
  int              cyc = 0;

  // Shared status pins: device level where it drives, bench level elsewhere
  assign st_i = (st_oe & st_o) | (~st_oe & pin_drv);
  always #2.5 pclk = ~pclk;

  ccd_ref_model i_src (.ref_input_a(ra), .ref_input_b(rb), .ref_input_c(rc),
                       .oscillator_input(osc));
  ccd_clock_divide_delay #(.NUM_OUT(6)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_input_a(ra), .ref_input_b(rb), .ref_input_c(rc),
    .ref_status_pin_i(st_i), .ref_status_pin_o(st_o), .ref_status_pin_oe(st_oe),
    .oscillator_input(osc), .sync_in(sync_in), .ref_to_pll(ref_o), .path_clk(path),
    .oscillator_buffered_output(obuf), .clk_out(clk_out), .feedback_clk(fbk),
    .xtal_enable(xtal), .fine_delay_ps(fine)
  );

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [31:0] e, input logic [31:0] m,
                     input logic er);
    int t;
    t = 0;
    @(posedge pclk);
    exp_q.push_back(e);
    msk_q.push_back(m);
    err_q.push_back(er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      t++;
    end
    while (pready !== 1'b1 && t < 40);
    if (t >= 40)
      chk(1'b0, "no bus answer");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf, 32'h0, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, 4'hf, e, m, 1'b0);
  endtask

  // Watches outputs 1, 2 and 5 for a window after a sync release
  task automatic watch(output int hi, output logic acc);
    hi = 0;
    acc = 1'b0;
    repeat (60)
    begin
      @(posedge pclk);
      hi += (clk_out[1] === 1'b1);
      acc |= (clk_out[1] !== clk_out[2]) | (clk_out[1] !== clk_out[5]);
    end
  endtask

  // Counts reference rises and path clock toggles; flags feedback not following output 1
  task automatic span(input int len, output int nr, output int np, output logic bad);
    logic r0, p0, c0;
    nr = 0;
    np = 0;
    bad = 1'b0;
    r0 = ref_o;
    p0 = path;
    c0 = clk_out[1];
    repeat (len)
    begin
      @(posedge pclk);
      nr += (ref_o === 1'b1 && r0 === 1'b0);
      np += (path !== p0);
      bad |= (fbk !== c0);
      r0 = ref_o;
      p0 = path;
      c0 = clk_out[1];
    end
  endtask

  task results;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
    begin
      chk((prdata & msk_q[0]) === (exp_q[0] & msk_q[0]) && pslverr === err_q[0], "bus answer");
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
      void'(err_q.pop_front());
    end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      results();
    end
  end

  initial
  begin
    int k;
    int n;
    int m;
    logic [4:0] c;
    logic en, p, acc;
    logic [9:0] ef;
    void'($urandom(32'hcf59));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(ccd_pkg::CTRL_OFS, ccd_pkg::CTRL_RST, ALL);
    rd(ccd_pkg::OUT_BASE_OFS, ccd_pkg::OUT_RST, ALL);
    rd(ccd_pkg::OUT_BASE_OFS + 8'h14, ccd_pkg::OUT_RST, ALL);
    chk(st_oe === 3'h7 && xtal === 1'b0, "reset outputs");
    $display("test reset done");
    apb(1'b0, 8'h08, 32'h0, 4'hf, 32'h0, ALL, 1'b1);
    apb(1'b1, 8'h28, ALL, 4'hf, 32'h0, 32'h0, 1'b1);
    wr(ccd_pkg::STAT_OFS, ALL);
    apb(1'b1, ccd_pkg::CTRL_OFS, ALL, 4'h8, 32'h0, 32'h0, 1'b0);
    apb(1'b1, ccd_pkg::CTRL_OFS, 32'hffff_ff01, 4'h1, 32'h0, 32'h0, 1'b0);
    rd(ccd_pkg::CTRL_OFS, 32'hff02_0001, ALL);
    chk(xtal === 1'b1 && st_oe === 3'h0, "crystal or pin mode");
    $display("test bus refusals done");
    for (k = 0; k < 3; k++)
    begin
      pin_drv <= 3'h7 << k;
      repeat (10) @(posedge pclk);
      rd(ccd_pkg::STAT_OFS, 32'(k), 32'h3);
    end
    for (k = 0; k < 3; k++)
    begin
      wr(ccd_pkg::CTRL_OFS, 32'h0002_0000 | 32'(k << 2) | 32'(k << 6));
      repeat (10) @(posedge pclk);
      rd(ccd_pkg::CTRL_OFS, 32'h0002_0000 | 32'(k << 2) | 32'(k << 6), ALL);
      rd(ccd_pkg::STAT_OFS, 32'(k), 32'h3);
    end
    for (k = 0; k < 4; k++)
    begin
      wr(ccd_pkg::CTRL_OFS, 32'h0002_0000 | 32'(k << 6));
      span(20, n, m, acc);
      span(280, n, m, acc);
      chk(n >= (41 >> k) - 1 && n <= (41 >> k) + 1, "reference pre-divide");
    end
    $display("test reference choice done");
    wr(ccd_pkg::OUT_BASE_OFS + 8'h04, 32'h0000_2819);
    wr(ccd_pkg::OUT_BASE_OFS + 8'h08, 32'h0000_281a);
    wr(ccd_pkg::OUT_BASE_OFS + 8'h0c, 32'h0000_2c15);
    wr(ccd_pkg::OUT_BASE_OFS + 8'h14, 32'h0000_2c14);
    rd(ccd_pkg::STAT_OFS, 32'h0000_0580, 32'h0000_07e0);
    $display("test extended mode done");
    for (k = 0; k < 6; k++)
    begin
      c = 5'($urandom_range(31));
      en = 1'($urandom_range(1));
      wr(ccd_pkg::OUT_BASE_OFS + 8'(4 * k),
         {1'b0, en, c, 2'b00, (k == 0), 1'b0, 10'h005, (k == 0) ? 11'h002 : 11'h003});
      repeat (4) @(posedge pclk);
      ef = {5'h0, (c > ccd_pkg::FINE_MAX) ? ccd_pkg::FINE_MAX : c};
      ef = en ? ccd_pkg::FINE_OFS_PS + ccd_pkg::FINE_STEP_PS * ef : 10'h000;
      chk(fine[k] === ef, "fine delay");
    end
    $display("test fine delay done");
    sync_in <= 1'b1;
    repeat (10) @(posedge pclk);
    rd(ccd_pkg::STAT_OFS, 32'h800, 32'h800);
    n = 0;
    acc = 1'b0;
    p = clk_out[0];
    repeat (20)
    begin
      @(posedge pclk);
      n += (clk_out[0] !== p);
      p = clk_out[0];
      acc |= (|clk_out[5:1]) | obuf;
    end
    chk(n >= 8, "exempt output stalled");
    chk(acc === 1'b0, "output ran during sync");
    sync_in <= 1'b0;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (clk_out[1] !== 1'b1 && k < 300);
    chk(k < 300, "no restart after sync");
    watch(n, acc);
    chk(n == 30, "odd ratio duty");
    chk(acc === 1'b0, "outputs not aligned");
    wr(ccd_pkg::OUT_BASE_OFS + 8'h08, 32'h0000_4803);
    watch(n, acc);
    chk(acc === 1'b0, "delay applied before sync");
    sync_in <= 1'b1;
    repeat (12) @(posedge pclk);
    sync_in <= 1'b0;
    repeat (40) @(posedge pclk);
    watch(n, acc);
    chk(acc === 1'b1, "delay not applied at sync");
    $display("test sync done");
    wr(ccd_pkg::CTRL_OFS, 32'h004b_8000);
    span(20, n, m, acc);
    span(60, n, m, acc);
    chk(m == 20, "path clock divide");
    chk(acc === 1'b0, "feedback mux");
    $display("test path and feedback done");
    results();
  end
endmodule
